// file: src/rsq_pkg.sv
// shared constants and types for the processor reset sequencer
package rsq_pkg;
   // register byte offsets
   localparam logic [7:0] RSQ_OFF_CTRL   = 8'h00;
   localparam logic [7:0] RSQ_OFF_STATUS = 8'h04;
   localparam logic [7:0] RSQ_OFF_PC     = 8'h08;
   localparam logic [7:0] RSQ_OFF_ST     = 8'h0c;
   localparam logic [7:0] RSQ_OFF_IE     = 8'h10;
   localparam logic [7:0] RSQ_OFF_IF     = 8'h14;
   localparam logic [7:0] RSQ_OFF_IOF    = 8'h18;
   // field positions
   localparam int RSQ_CTRL_BOOT_HOLD   = 0;
   localparam int RSQ_STAT_IN_RESET    = 0;
   localparam int RSQ_STAT_SHORT       = 1;
   localparam int RSQ_STAT_RUN         = 2;
   localparam int RSQ_STAT_STATE_LSB   = 4;
   localparam int RSQ_STAT_CNT_LSB     = 8;
   // reset values and timing counts
   localparam logic [31:0] RSQ_CORE_REG_RST = 32'h0000_0000;
   localparam logic [23:0] RSQ_RESET_VECTOR = 24'h00_0000;
   localparam int          RSQ_RESET_MIN_H1 = 10;
   localparam int          RSQ_MCLK_PER_H1  = 4;
   localparam int          RSQ_SERIAL_PINS  = 12;

   typedef enum logic [1:0] {
      RSQ_POWERUP,
      RSQ_RESET,
      RSQ_FETCH,
      RSQ_RUN
   } rsq_state_e;

   typedef struct packed {
      rsq_state_e  state;
      logic        rst_pin_q;
      logic        sync_rst;
      logic [7:0]  low_cnt;
      logic        short_reset;
      logic        boot_hold;
      logic [23:0] pc;
      logic [31:0] st;
      logic [31:0] ie;
      logic [31:0] ifl;
      logic [31:0] io_flag_word;
      logic        pri_bus_oe;
      logic        exp_bus_oe;
      logic [3:0]  strobe_n;
      logic [1:0]  flag_oe;
      logic [11:0] serial_oe;
      logic [1:0]  timer_oe;
      logic        periph_reset;
      logic        core_run;
      logic        vec_rd_req;
      logic        ready_q;
      logic        xready_q;
      logic        hold_req_q;
      logic        hold_grant_q;
      logic [3:0]  int_q;
      logic        mode_q;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } rsq_state_s;
endpackage : rsq_pkg

// file: src/rsq_phase_gen.sv
// two-phase output clock generator with phase alignment
`timescale 1ns/10ps
`default_nettype none
module rsq_phase_gen #(
   parameter int PER = rsq_pkg::RSQ_MCLK_PER_H1
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic align,
   output var  logic phase_one,
   output var  logic phase_three,
   output var  logic h1_tick
);
   localparam int CW = (PER > 2) ? $clog2(PER) : 1;
   localparam logic [CW-1:0] LAST = CW'(PER - 1);
   localparam logic [CW-1:0] HALF = CW'(PER / 2);

   initial
   begin
      if (PER < 2 || (PER % 2) != 0)
         $error("rsq_phase_gen: PER must be even and at least 2");
   end

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          ph1;
      logic          ph3;
      logic          tick;
   } rsq_phase_s;

   rsq_phase_s cur;
   rsq_phase_s next_cur;

   always_comb
   begin
      next_cur = cur;
      // falling reset edge forces the fixed initial phase
      if (align || cur.cnt == LAST)
         next_cur.cnt = '0;
      else
         next_cur.cnt = cur.cnt + CW'(1);
      next_cur.ph1  = (next_cur.cnt < HALF);
      next_cur.ph3  = !(next_cur.cnt < HALF);
      next_cur.tick = (next_cur.cnt == '0);
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cur.cnt  <= '0;
         cur.ph1  <= 1'b1;
         cur.ph3  <= 1'b0;
         cur.tick <= 1'b0;
      end
      else
         cur <= next_cur;
   end

   assign phase_one   = cur.ph1;
   assign phase_three = cur.ph3;
   assign h1_tick     = cur.tick;

   AST_ALIGN_PHASE: assert property (@(posedge mclk) disable iff (rst)
      align |=> phase_one && !phase_three && h1_tick)
      else $error("phase not at initial state after reset edge");
   AST_ALIGN_HOLD: assert property (@(posedge mclk) disable iff (rst)
      align ##1 !align |=> !h1_tick && phase_one)
      else $error("phase sequence wrong after alignment");
endmodule : rsq_phase_gen
`default_nettype wire

// file: src/rsq_sequencer.sv
// processor reset sequencer: pin reset states, core register clear, vector fetch
//
// Contract
// - reset pin is nonmaskable; no enable or state blocks it
// - during reset both bus groups released to high impedance via clocked path
// - clocked reset drives primary, both expansion strobes and acknowledge high
// - flag, serial and timer pins released immediately by the direct path
// - ready, hold request, hold grant, interrupts and mode input unaffected
// - clocked pin reset follows internal clock; direct pin reset acts sooner
// - both output clock phases return to initial state on reset falling edge
// - first-phase clock generated here, output, and used to count reset length
// - peripherals reset synchronously during system reset
// - status, interrupt enable, interrupt flag and io flag words cleared
// - after reset, fetch vector from address zero into program counter, run unless boot hold is set
// - reset falling edge puts device on a fixed phase for multi-device sync
// - nothing relied on before the first reset; pins stay released
`timescale 1ns/10ps
`default_nettype none
module rsq_sequencer #(
   parameter int RESET_MIN_H1 = rsq_pkg::RSQ_RESET_MIN_H1
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ext_reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // output clocks
   output var  logic        phase_one_clock_out,
   output var  logic        phase_three_clock_out,
   // requested pin drive from the core
   input  wire logic        core_pri_bus_oe,
   input  wire logic        core_exp_bus_oe,
   input  wire logic [3:0]  core_strobe_n,
   input  wire logic [1:0]  core_flag_oe,
   input  wire logic [11:0] core_serial_oe,
   input  wire logic [1:0]  core_timer_oe,
   input  wire logic        core_hold_grant,
   // pin drive after reset forcing
   output var  logic        primary_bus_oe,
   output var  logic        expansion_bus_oe,
   output var  logic        primary_bus_strobe_n,
   output var  logic        expansion_memory_strobe_n,
   output var  logic        expansion_io_strobe_n,
   output var  logic        interrupt_ack_out_n,
   output var  logic [1:0]  external_flag_pins_oe,
   output var  logic [11:0] serial_pins_oe,
   output var  logic        timer_zero_pin_oe,
   output var  logic        timer_one_pin_oe,
   output var  logic        bus_hold_grant,
   // inputs that reset leaves alone
   input  wire logic        ready_in,
   input  wire logic        expansion_ready_in,
   input  wire logic        hold_req_in,
   input  wire logic [3:0]  external_interrupt_inputs,
   input  wire logic        microcomputer_mode_select,
   output var  logic        core_ready,
   output var  logic        core_expansion_ready,
   output var  logic        core_hold_req,
   output var  logic [3:0]  core_interrupts,
   output var  logic        core_mode_select,
   // vector fetch and core control
   output var  logic        vec_rd_req,
   output var  logic [23:0] vec_rd_addr,
   input  wire logic        vec_rd_valid,
   input  wire logic [31:0] vec_rd_data,
   output var  logic [23:0] program_counter,
   output var  logic        core_run,
   output var  logic        periph_reset
);
   initial
   begin
      if (RESET_MIN_H1 < 1 || RESET_MIN_H1 > 255)
         $error("rsq_sequencer: RESET_MIN_H1 must lie in 1..255");
   end

   localparam logic [7:0] MIN_CNT = 8'(RESET_MIN_H1);

   rsq_pkg::rsq_state_s cur;
   rsq_pkg::rsq_state_s next_cur;

   logic h1_tick;
   logic align;
   logic powerup;
   logic force_sync;
   logic pin_low;
   logic wr_done;
   logic [31:0] rd_val;
   logic        rd_err;

   // falling edge of the reset pin, seen on the raw synchronous input
   assign align      = cur.rst_pin_q && !ext_reset_n;
   assign powerup    = (cur.state == rsq_pkg::RSQ_POWERUP);
   assign force_sync = cur.sync_rst || powerup;
   assign pin_low    = !ext_reset_n;
   assign wr_done    = psel && penable && pwrite && cur.pready;

   rsq_phase_gen #(
      .PER (rsq_pkg::RSQ_MCLK_PER_H1)
   ) u_phase (
      .mclk        (mclk),
      .rst         (rst),
      .align       (align),
      .phase_one   (phase_one_clock_out),
      .phase_three (phase_three_clock_out),
      .h1_tick     (h1_tick)
   );

   // read mux, used when the access phase is answered
   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr == rsq_pkg::RSQ_OFF_CTRL)
         rd_val[rsq_pkg::RSQ_CTRL_BOOT_HOLD] = cur.boot_hold;
      else if (paddr == rsq_pkg::RSQ_OFF_STATUS)
      begin
         rd_val[rsq_pkg::RSQ_STAT_IN_RESET] = cur.sync_rst;
         rd_val[rsq_pkg::RSQ_STAT_SHORT]    = cur.short_reset;
         rd_val[rsq_pkg::RSQ_STAT_RUN]      = cur.core_run;
         rd_val[rsq_pkg::RSQ_STAT_STATE_LSB +: 2] = cur.state;
         rd_val[rsq_pkg::RSQ_STAT_CNT_LSB +: 8]   = cur.low_cnt;
      end
      else if (paddr == rsq_pkg::RSQ_OFF_PC)
         rd_val[23:0] = cur.pc;
      else if (paddr == rsq_pkg::RSQ_OFF_ST)
         rd_val = cur.st;
      else if (paddr == rsq_pkg::RSQ_OFF_IE)
         rd_val = cur.ie;
      else if (paddr == rsq_pkg::RSQ_OFF_IF)
         rd_val = cur.ifl;
      else if (paddr == rsq_pkg::RSQ_OFF_IOF)
         rd_val = cur.io_flag_word;
      else
         rd_err = 1'b1;
   end

   always_comb
   begin
      next_cur = cur;
      next_cur.rst_pin_q = ext_reset_n;

      // clocked reset level changes only on the first-phase tick; no
      // enable or state takes part in it
      if (h1_tick)
         next_cur.sync_rst = pin_low;

      // reset length counted in first-phase cycles, saturating
      if (align)
         next_cur.low_cnt = 8'h00;
      else if (h1_tick && pin_low && cur.low_cnt != 8'hff)
         next_cur.low_cnt = cur.low_cnt + 8'h01;

      case (cur.state)
         rsq_pkg::RSQ_POWERUP:
         begin
            // no assumption about anything until a reset is seen
            if (pin_low)
               next_cur.state = rsq_pkg::RSQ_RESET;
         end
         rsq_pkg::RSQ_RESET:
         begin
            // leave only when the clocked reset level is released
            if (!cur.sync_rst && !pin_low)
            begin
               next_cur.state       = rsq_pkg::RSQ_FETCH;
               next_cur.short_reset = (cur.low_cnt < MIN_CNT);
            end
         end
         rsq_pkg::RSQ_FETCH:
         begin
            if (cur.sync_rst)
               next_cur.state = rsq_pkg::RSQ_RESET;
            else if (cur.vec_rd_req && vec_rd_valid)
            begin
               next_cur.pc    = vec_rd_data[23:0];
               next_cur.state = rsq_pkg::RSQ_RUN;
            end
         end
         rsq_pkg::RSQ_RUN:
         begin
            if (cur.sync_rst)
               next_cur.state = rsq_pkg::RSQ_RESET;
         end
         default:
            next_cur.state = rsq_pkg::RSQ_POWERUP;
      endcase

      // request held from the fetch state, dropped on any reset
      next_cur.vec_rd_req = (next_cur.state == rsq_pkg::RSQ_FETCH) && !next_cur.sync_rst;
      next_cur.core_run   = (next_cur.state == rsq_pkg::RSQ_RUN) && !next_cur.sync_rst
                            && !cur.boot_hold;
      next_cur.periph_reset = force_sync;

      // clocked pin group: buses released, strobes high
      next_cur.pri_bus_oe = force_sync ? 1'b0 : core_pri_bus_oe;
      next_cur.exp_bus_oe = force_sync ? 1'b0 : core_exp_bus_oe;
      next_cur.strobe_n   = force_sync ? 4'hf : core_strobe_n;

      // direct pin group follows the raw pin, a tick earlier at most
      next_cur.flag_oe   = (pin_low || powerup) ? 2'h0 : core_flag_oe;
      next_cur.serial_oe = (pin_low || powerup) ? 12'h000 : core_serial_oe;
      next_cur.timer_oe  = (pin_low || powerup) ? 2'h0 : core_timer_oe;

      // untouched by the sequencer's own reset
      next_cur.ready_q      = ready_in;
      next_cur.xready_q     = expansion_ready_in;
      next_cur.hold_req_q   = hold_req_in;
      next_cur.hold_grant_q = core_hold_grant;
      next_cur.int_q        = external_interrupt_inputs;
      next_cur.mode_q       = microcomputer_mode_select;

      // apb: answer one cycle into the access phase; write at completion
      next_cur.pready = psel && penable && !cur.pready;
      if (psel && penable && !cur.pready)
      begin
         next_cur.prdata  = pwrite ? 32'h0000_0000 : rd_val;
         next_cur.pslverr = rd_err;
      end
      else if (!psel)
      begin
         next_cur.prdata  = 32'h0000_0000;
         next_cur.pslverr = 1'b0;
      end

      if (wr_done && !rd_err)
      begin
         if (paddr == rsq_pkg::RSQ_OFF_CTRL)
            next_cur.boot_hold = pwdata[rsq_pkg::RSQ_CTRL_BOOT_HOLD];
         else if (paddr == rsq_pkg::RSQ_OFF_ST)
            next_cur.st = pwdata;
         else if (paddr == rsq_pkg::RSQ_OFF_IE)
            next_cur.ie = pwdata;
         else if (paddr == rsq_pkg::RSQ_OFF_IF)
            next_cur.ifl = pwdata;
         else if (paddr == rsq_pkg::RSQ_OFF_IOF)
            next_cur.io_flag_word = pwdata;
      end

      // system reset wins over a software write in the same cycle
      if (force_sync)
      begin
         next_cur.st  = rsq_pkg::RSQ_CORE_REG_RST;
         next_cur.ie  = rsq_pkg::RSQ_CORE_REG_RST;
         next_cur.ifl = rsq_pkg::RSQ_CORE_REG_RST;
         next_cur.io_flag_word = rsq_pkg::RSQ_CORE_REG_RST;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cur              <= '0;
         cur.state        <= rsq_pkg::RSQ_POWERUP;
         cur.rst_pin_q    <= 1'b1;
         cur.strobe_n     <= 4'hf;
         cur.periph_reset <= 1'b1;
      end
      else
         cur <= next_cur;
   end

   assign prdata                    = cur.prdata;
   assign pready                    = cur.pready;
   assign pslverr                   = cur.pslverr;
   assign primary_bus_oe            = cur.pri_bus_oe;
   assign expansion_bus_oe          = cur.exp_bus_oe;
   assign primary_bus_strobe_n      = cur.strobe_n[0];
   assign expansion_memory_strobe_n = cur.strobe_n[1];
   assign expansion_io_strobe_n     = cur.strobe_n[2];
   assign interrupt_ack_out_n       = cur.strobe_n[3];
   assign external_flag_pins_oe     = cur.flag_oe;
   assign serial_pins_oe            = cur.serial_oe;
   assign timer_zero_pin_oe         = cur.timer_oe[0];
   assign timer_one_pin_oe          = cur.timer_oe[1];
   assign bus_hold_grant            = cur.hold_grant_q;
   assign core_ready                = cur.ready_q;
   assign core_expansion_ready      = cur.xready_q;
   assign core_hold_req             = cur.hold_req_q;
   assign core_interrupts           = cur.int_q;
   assign core_mode_select          = cur.mode_q;
   assign vec_rd_req                = cur.vec_rd_req;
   assign vec_rd_addr               = rsq_pkg::RSQ_RESET_VECTOR;
   assign program_counter           = cur.pc;
   assign core_run                  = cur.core_run;
   assign periph_reset              = cur.periph_reset;

   AST_NMI_TAKEN: assert property (@(posedge mclk) disable iff (rst)
      (pin_low && h1_tick) |=> cur.sync_rst)
      else $error("reset pin low at tick but clocked reset not raised");
   AST_BUS_HIZ: assert property (@(posedge mclk) disable iff (rst)
      cur.sync_rst |=> !primary_bus_oe && !expansion_bus_oe)
      else $error("bus drive enabled during reset");
   AST_STROBES_HIGH: assert property (@(posedge mclk) disable iff (rst)
      cur.sync_rst |=> primary_bus_strobe_n && expansion_memory_strobe_n
                       && expansion_io_strobe_n && interrupt_ack_out_n)
      else $error("strobe asserted during reset");
   AST_DIRECT_HIZ: assert property (@(posedge mclk) disable iff (rst)
      pin_low |=> external_flag_pins_oe == 2'h0 && serial_pins_oe == 12'h000
                  && !timer_zero_pin_oe && !timer_one_pin_oe)
      else $error("direct-reset pins driven while reset low");
   AST_PASS_THROUGH: assert property (@(posedge mclk) disable iff (rst)
      !$past(rst) |-> core_interrupts == $past(external_interrupt_inputs)
                      && core_hold_req == $past(hold_req_in)
                      && bus_hold_grant == $past(core_hold_grant))
      else $error("unaffected input altered by reset logic");
   AST_SYNC_ON_TICK: assert property (@(posedge mclk) disable iff (rst)
      $changed(cur.sync_rst) |-> $past(h1_tick))
      else $error("clocked reset level changed off the first-phase tick");
   AST_COUNT_ON_TICK: assert property (@(posedge mclk) disable iff (rst)
      (cur.low_cnt != 8'h00 && $changed(cur.low_cnt)) |-> $past(h1_tick) && $past(pin_low))
      else $error("reset length counter moved without a first-phase tick");
   AST_PERIPH_RESET: assert property (@(posedge mclk) disable iff (rst)
      cur.sync_rst |=> periph_reset)
      else $error("peripheral reset missing during system reset");
   AST_WORDS_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      cur.sync_rst |=> cur.st == 32'h0 && cur.ie == 32'h0 && cur.ifl == 32'h0
                       && cur.io_flag_word == 32'h0)
      else $error("core word not cleared by system reset");
   AST_VECTOR_LOAD: assert property (@(posedge mclk) disable iff (rst)
      (vec_rd_req && vec_rd_valid && !cur.sync_rst) |=>
         program_counter == $past(vec_rd_data[23:0]) && !vec_rd_req)
      else $error("reset vector not loaded into program counter");
   AST_POWERUP_QUIET: assert property (@(posedge mclk) disable iff (rst)
      powerup |=> !primary_bus_oe && !core_run && !vec_rd_req)
      else $error("activity before the first reset");
   AST_NO_FETCH_IN_RESET: assert property (@(posedge mclk) disable iff (rst)
      cur.sync_rst |=> !vec_rd_req && !core_run)
      else $error("fetch or execution while reset held");
   AST_SHORT_FLAG: assert property (@(posedge mclk) disable iff (rst)
      (cur.state == rsq_pkg::RSQ_RESET && next_cur.state == rsq_pkg::RSQ_FETCH)
         |=> cur.short_reset == ($past(cur.low_cnt) < MIN_CNT))
      else $error("short reset flag does not match counted length");
endmodule : rsq_sequencer
`default_nettype wire

// file: testbench/rsq_board_model.sv
// board reset source and reset-vector memory facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module rsq_board_model (
   input  wire logic        mclk,
   input  wire logic        start,
   input  wire logic [7:0]  low_cyc,
   input  wire logic [3:0]  vec_dly,
   input  wire logic [31:0] vector,
   input  wire logic        vec_rd_req,
   input  wire logic [23:0] vec_rd_addr,
   output var  logic        ext_reset_n,
   output var  logic        vec_rd_valid,
   output var  logic [31:0] vec_rd_data
);
   logic [7:0] cnt = 8'h00;
   logic [3:0] wt  = 4'h0;
   logic       vld = 1'b0;
   // pin held low for low_cyc mclk cycles
   assign ext_reset_n  = (cnt == 8'h00);
   assign vec_rd_valid = vld;
   // garbage outside the valid cycle or for a wrong address
   assign vec_rd_data  = (vld && vec_rd_addr == 24'h00_0000) ? vector : ~vector;
   always_ff @(posedge mclk)
   begin
      if (start)
         cnt <= low_cyc;
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
      vld <= vec_rd_req && !vld && wt == vec_dly;
      wt  <= (vec_rd_req && !vld) ? wt + 4'h1 : 4'h0;
   end
endmodule : rsq_board_model
`default_nettype wire

// file: testbench/tb_processor_reset_sequencer.sv
// self-checking bench for the processor reset sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_processor_reset_sequencer;
   logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        start = 1'b0, core_pri_bus_oe = 1'b1, core_exp_bus_oe = 1'b1;
   logic        core_hold_grant = 1'b0, ready_in = 1'b0, expansion_ready_in = 1'b0;
   logic        hold_req_in = 1'b0, microcomputer_mode_select = 1'b0, er;
   logic [1:0]  core_flag_oe = 2'h3, core_timer_oe = 2'h3;
   logic [3:0]  core_strobe_n = 4'h0, external_interrupt_inputs = 4'h0, vec_dly = 4'h0;
   logic [7:0]  paddr = 8'h00, low_cyc = 8'h00;
   logic [11:0] core_serial_oe = 12'hfff;
   logic [31:0] pwdata = 32'h0, vector = 32'h0, rd;
   logic        pready, pslverr, phase_one_clock_out, phase_three_clock_out, primary_bus_oe;
   logic        expansion_bus_oe, primary_bus_strobe_n, expansion_memory_strobe_n;
   logic        expansion_io_strobe_n, interrupt_ack_out_n, timer_zero_pin_oe, timer_one_pin_oe;
   logic        bus_hold_grant, core_ready, core_expansion_ready, core_hold_req;
   logic        core_mode_select, vec_rd_req, core_run, periph_reset, ext_reset_n, vec_rd_valid;
   logic [1:0]  external_flag_pins_oe;
   logic [3:0]  core_interrupts;
   logic [11:0] serial_pins_oe;
   logic [23:0] vec_rd_addr, program_counter;
   logic [31:0] prdata, vec_rd_data;
   int          comparisons = 0, error_cnt = 0, n;

   rsq_sequencer #(.RESET_MIN_H1(2)) i_dut (.mclk, .rst, .ext_reset_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_one_clock_out,
      .phase_three_clock_out, .core_pri_bus_oe, .core_exp_bus_oe, .core_strobe_n,
      .core_flag_oe, .core_serial_oe, .core_timer_oe, .core_hold_grant, .primary_bus_oe,
      .expansion_bus_oe, .primary_bus_strobe_n, .expansion_memory_strobe_n,
      .expansion_io_strobe_n, .interrupt_ack_out_n, .external_flag_pins_oe, .serial_pins_oe,
      .timer_zero_pin_oe, .timer_one_pin_oe, .bus_hold_grant, .ready_in, .expansion_ready_in,
      .hold_req_in, .external_interrupt_inputs, .microcomputer_mode_select, .core_ready,
      .core_expansion_ready, .core_hold_req, .core_interrupts, .core_mode_select, .vec_rd_req,
      .vec_rd_addr, .vec_rd_valid, .vec_rd_data, .program_counter, .core_run, .periph_reset);

   rsq_board_model i_board (.mclk, .start, .low_cyc, .vec_dly, .vector, .vec_rd_req,
      .vec_rd_addr, .ext_reset_n, .vec_rd_valid, .vec_rd_data);

   initial
   begin
      forever #5 mclk = ~mclk;
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : step

   // one apb transfer; read data and error land in rd and er
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      w = 0;
      do
      begin
         @(posedge mclk);
         w++;
      end
      while (pready !== 1'b1 && w < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w == 20)
         chk(0, 1);
   endtask : apb

   task automatic board_reset(input logic [7:0] lc, input logic [3:0] dl, input logic [31:0] v);
      @(posedge mclk);
      low_cyc <= lc;
      vec_dly <= dl;
      vector <= v;
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
   endtask : board_reset

   // bounded wait for the vector handshake, then let the load land
   task automatic wait_fetch;
      n = 0;
      while (vec_rd_valid !== 1'b1 && n < 200)
      begin
         step(1);
         n++;
      end
      chk(n < 200, 1);
      step(2);
   endtask : wait_fetch

   initial
   begin
      #20000;
      error_cnt++;
      final_report();
   end

   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      step(1);
      chk({primary_bus_oe, external_flag_pins_oe, primary_bus_strobe_n, core_run}, 5'b00010);
      apb(1'b0, rsq_pkg::RSQ_OFF_STATUS, 32'h0);
      chk(rd[5:4], 2'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, rsq_pkg::RSQ_OFF_ST + 8'(4 * i), 32'hc0de_0000 + 32'(i));
         apb(1'b0, rsq_pkg::RSQ_OFF_ST + 8'(4 * i), 32'h0);
         // core words held clear until the first reset is seen
         chk(rd, 32'h0);
      end
      apb(1'b0, 8'h1c, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      // long board reset with a prompt vector
      board_reset(8'd48, 4'h0, 32'hff12_3456);
      step(8);
      chk({primary_bus_oe, expansion_bus_oe, primary_bus_strobe_n, expansion_memory_strobe_n,
           expansion_io_strobe_n, interrupt_ack_out_n}, 6'b001111);
      chk({external_flag_pins_oe, serial_pins_oe, timer_zero_pin_oe, timer_one_pin_oe}, 0);
      chk({periph_reset, vec_rd_req, core_run}, 3'b100);
      @(posedge mclk);
      external_interrupt_inputs <= 4'ha;
      ready_in <= 1'b1;
      expansion_ready_in <= 1'b1;
      hold_req_in <= 1'b1;
      microcomputer_mode_select <= 1'b1;
      core_hold_grant <= 1'b1;
      core_timer_oe <= 2'h1;
      step(2);
      chk({core_interrupts, core_ready, core_expansion_ready, core_hold_req, core_mode_select,
           bus_hold_grant}, 9'h15f);
      n = 0;
      repeat (16)
      begin
         step(1);
         n += (phase_one_clock_out === 1'b1);
         chk(phase_three_clock_out, !phase_one_clock_out);
      end
      chk(n, 8);
      // write while in reset must not survive
      apb(1'b1, rsq_pkg::RSQ_OFF_ST, 32'h1);
      wait_fetch();
      chk(program_counter, 24'h12_3456);
      chk({core_run, periph_reset, primary_bus_oe, external_flag_pins_oe}, 5'b10111);
      chk({primary_bus_strobe_n, expansion_memory_strobe_n, expansion_io_strobe_n,
           interrupt_ack_out_n, expansion_bus_oe, timer_zero_pin_oe, timer_one_pin_oe},
          7'b0000110);
      chk(serial_pins_oe, 12'hfff);
      chk(vec_rd_addr, 24'h00_0000);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, rsq_pkg::RSQ_OFF_ST + 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, rsq_pkg::RSQ_OFF_ST + 8'(4 * i), 32'h5a00_0000 + 32'(i));
         apb(1'b0, rsq_pkg::RSQ_OFF_ST + 8'(4 * i), 32'h0);
         chk(rd, 32'h5a00_0000 + 32'(i));
      end
      apb(1'b0, rsq_pkg::RSQ_OFF_STATUS, 32'h0);
      chk(rd[5:0], 6'b110100);
      apb(1'b1, rsq_pkg::RSQ_OFF_PC, 32'h0);
      apb(1'b0, rsq_pkg::RSQ_OFF_PC, 32'h0);
      chk(rd[23:0], 24'h12_3456);
      // boot hold set, short pulse, slow vector: reset must still act
      apb(1'b1, rsq_pkg::RSQ_OFF_CTRL, 32'h1);
      board_reset(8'd4, 4'h5, 32'h0000_0abc);
      step(2);
      chk({phase_one_clock_out, phase_three_clock_out, external_flag_pins_oe, primary_bus_oe},
          5'b10001);
      chk({serial_pins_oe, timer_zero_pin_oe, timer_one_pin_oe}, 0);
      // second cycle after alignment: first phase must have fallen
      step(1);
      chk({phase_one_clock_out, phase_three_clock_out}, 2'b01);
      step(2);
      chk({primary_bus_oe, expansion_bus_oe, core_run, periph_reset, primary_bus_strobe_n,
           expansion_memory_strobe_n, expansion_io_strobe_n, interrupt_ack_out_n},
          8'b0001_1111);
      wait_fetch();
      chk({core_run, program_counter}, {1'b0, 24'h00_0abc});
      // words written while running must be gone after this reset
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, rsq_pkg::RSQ_OFF_ST + 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, rsq_pkg::RSQ_OFF_STATUS, 32'h0);
      chk(rd[1], 1'b1);
      final_report();
   end
endmodule : tb_processor_reset_sequencer
`default_nettype wire
